// ### hw/power_mode_pkg.sv
// shared constants and types for the power mode and reset controller
package power_mode_pkg;

  // clock and reset-pin filter timing
  localparam int CLK_PERIOD_NS     = 5;
  localparam int EXT_FILTER_NS     = 100;
  localparam int EXT_FILTER_CYCLES =
    (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets on the bus
  localparam int         ADDR_W             = 5;
  localparam logic [4:0] OSC_CTRL_OFFSET    = 5'h00;
  localparam logic [4:0] RESET_CTRL_OFFSET  = 5'h04;
  localparam logic [4:0] MODE_STATUS_OFFSET = 5'h08;
  localparam logic [4:0] IRQ_STATUS_OFFSET  = 5'h0c;
  localparam logic [4:0] IRQ_MASK_OFFSET    = 5'h10;

  // field positions
  localparam int IDLE_SEL_BIT    = 7;
  localparam int SRC_SEL_LSB     = 0;
  localparam int POR_FLAG_BIT    = 1;
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_SRC_LSB    = 4;
  localparam int STAT_PIN_BIT    = 6;
  localparam int STAT_PEND_BIT   = 7;

  // reset values
  localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
  localparam logic       POR_FLAG_RESET = 1'b0;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

  // clock sources, also the index into the running and enable vectors
  localparam int         NUM_SOURCES   = 3;
  localparam logic [1:0] SRC_PRIMARY   = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam logic [1:0] SRC_INTERNAL  = 2'h2;

  // interrupt event bits
  localparam int EVT_W     = 5;
  localparam int EVT_IDLE  = 0;
  localparam int EVT_SLEEP = 1;
  localparam int EVT_WAKE  = 2;
  localparam int EVT_PIN   = 3;
  localparam int EVT_POR   = 4;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP} pm_state_e;

  // select 1x means the internal block whatever bit 0 holds
  function automatic logic [1:0] src_of(input logic [1:0] sel);
    src_of = sel[1] ? SRC_INTERNAL : sel;
  endfunction

endpackage

// ### hw/reset_pin_filter.sv
// glitch filter for the external reset pin
`timescale 1ns/1ps
module reset_pin_filter #(
  parameter int FILTER_CYCLES = power_mode_pkg::EXT_FILTER_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      pin_filtered
);
  import power_mode_pkg::*;

  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILTER_CYCLES - 1);

  logic [CNT_W-1:0] stable_cnt;

  // count cycles the pin differs from the filtered level; short pulses
  // restart the count so they never reach the output
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stable_cnt <= '0;
    end else if (pin_in == pin_filtered) begin
      stable_cnt <= '0;
    end else if (stable_cnt == CNT_LAST) begin
      stable_cnt <= '0;
    end else begin
      stable_cnt <= stable_cnt + CNT_W'(1);
    end
  end

  // filtered level idles high, the inactive level of the pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_filtered <= 1'b1;
    end else if (pin_in != pin_filtered && stable_cnt == CNT_LAST) begin
      pin_filtered <= pin_in;
    end
  end

  chk_filter_short: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pin_in != pin_filtered && stable_cnt == '0) |=>
      pin_filtered == $past(pin_filtered))
    else $error("filter passed a one-cycle pulse");

endmodule

// ### hw/power_mode_and_reset_control.sv
// power mode selection, reset pin handling and power-on flag with bus regs
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module power_mode_and_reset_control #(
  parameter int FILTER_CYCLES = power_mode_pkg::EXT_FILTER_CYCLES
) (
  input  wire logic                                clk_sys,
  input  wire logic                                rst_b,
  // avalon-mm slave
  input  wire logic [power_mode_pkg::ADDR_W-1:0]   address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [31:0]                         writedata,
  input  wire logic [3:0]                          byteenable,
  output logic      [31:0]                         readdata,
  output logic                                     waitrequest,
  // cpu core
  input  wire logic                                sleep_exec,
  input  wire logic                                wake_event,
  // sources and supply
  input  wire logic [power_mode_pkg::NUM_SOURCES-1:0] source_running,
  input  wire logic                                supply_good,
  // external reset pin
  input  wire logic                                ext_reset_pin_in,
  output logic                                     ext_reset_pin_out,
  output logic                                     ext_reset_pin_oe,
  input  wire logic                                external_reset_pin_enable,
  output logic                                     pin_digital_in,
  // clock and reset control
  output logic                                     cpu_clk_en,
  output logic                                     periph_clk_en,
  output logic      [power_mode_pkg::NUM_SOURCES-1:0] clk_src_en,
  output logic      [2:0]                          internal_block_en,
  output logic                                     device_reset,
  output logic                                     por_pulse,
  output logic                                     irq
);
  import power_mode_pkg::*;

  logic [7:0]       osc_ctrl;
  logic             por_flag;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  pm_state_e        pm_state;
  logic [1:0]       active_src;
  logic             supply_good_q;
  logic             pin_filtered;
  logic             por_event;
  logic             pin_hold;
  logic             init_req;
  logic             bus_wr;
  logic             lane0_wr;
  logic [1:0]       sel_src;
  logic             switch_pend;
  logic [EVT_W-1:0] events;

  // power-on reset on a rising supply-good level; the history starts high
  // so a supply already good at rst_b release is no second power-on
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      supply_good_q <= 1'b1;
    end else begin
      supply_good_q <= supply_good;
    end
  end
  assign por_event = supply_good & ~supply_good_q;

  reset_pin_filter #(
    .FILTER_CYCLES (FILTER_CYCLES)
  ) u_pin_filter (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .pin_in       (ext_reset_pin_in),
    .pin_filtered (pin_filtered)
  );

  // pin resets only while the function is enabled
  assign pin_hold = external_reset_pin_enable & ~pin_filtered;
  assign init_req = pin_hold | por_event;

  // bus write strobe: effect at the edge waitrequest is low
  assign bus_wr   = write & ~waitrequest;
  assign lane0_wr = bus_wr & byteenable[0];
  assign sel_src  = src_of(osc_ctrl[SRC_SEL_LSB +: 2]);

  // one wait cycle per access, then a single acknowledge cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
    end else if (waitrequest && (read || write)) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // read data latched with the acknowledge; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= '0;
    end else if (read && waitrequest) begin
      readdata <= '0;
      case (address)
        OSC_CTRL_OFFSET: begin
          readdata[7:0] <= osc_ctrl;
        end
        RESET_CTRL_OFFSET: begin
          readdata[POR_FLAG_BIT] <= por_flag;
        end
        MODE_STATUS_OFFSET: begin
          readdata[STAT_STATE_LSB +: 2] <= pm_state;
          readdata[STAT_SRC_LSB +: 2]   <= active_src;
          readdata[STAT_PIN_BIT]        <= pin_filtered;
          readdata[STAT_PEND_BIT]       <= switch_pend;
        end
        IRQ_STATUS_OFFSET: begin
          readdata[EVT_W-1:0] <= irq_status;
        end
        IRQ_MASK_OFFSET: begin
          readdata[EVT_W-1:0] <= irq_mask;
        end
        default: begin
          readdata <= '0;
        end
      endcase
    end
  end

  // control register: only bit 7 and bits 1:0 exist, the rest read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_ctrl <= OSC_CTRL_RESET;
    end else if (init_req) begin
      osc_ctrl <= OSC_CTRL_RESET;
    end else if (lane0_wr && address == OSC_CTRL_OFFSET) begin
      osc_ctrl[IDLE_SEL_BIT]     <= writedata[IDLE_SEL_BIT];
      osc_ctrl[SRC_SEL_LSB +: 2] <= writedata[SRC_SEL_LSB +: 2];
    end
  end

  // power-on flag: hardware only clears it, a pin reset leaves it alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      por_flag <= POR_FLAG_RESET;
    end else if (por_event) begin
      por_flag <= 1'b0;
    end else if (lane0_wr && address == RESET_CTRL_OFFSET) begin
      por_flag <= writedata[POR_FLAG_BIT];
    end
  end

  // active source follows the select once the target source runs;
  // a stopped target leaves the old clock in place until it starts
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_src <= SRC_PRIMARY;
    end else if (init_req) begin
      active_src <= SRC_PRIMARY;
    end else if (sel_src != active_src && source_running[sel_src]) begin
      active_src <= sel_src;
    end
  end
  assign switch_pend = sel_src != active_src;

  // mode state: idle and sleep only from a sleep instruction in run
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pm_state <= PM_RUN;
    end else if (init_req) begin
      pm_state <= PM_RUN;
    end else begin
      case (pm_state)
        PM_RUN: begin
          if (sleep_exec) begin
            // idle select as it stands when the instruction runs
            pm_state <= osc_ctrl[IDLE_SEL_BIT] ? PM_IDLE
                                               : PM_SLEEP;
          end
        end
        PM_IDLE, PM_SLEEP: begin
          if (wake_event) begin
            pm_state <= PM_RUN;
          end
        end
        default: begin
          pm_state <= PM_RUN;
        end
      endcase
    end
  end

  // clock gating from the state; source held by active_src on wake
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
    end else begin
      cpu_clk_en    <= pm_state == PM_RUN;
      periph_clk_en <= pm_state != PM_SLEEP;
    end
  end

  // one source enable per oscillator, all off in sleep
  generate
    for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_src_en
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          clk_src_en[i] <= (i == int'(SRC_PRIMARY));
        end else begin
          clk_src_en[i] <= pm_state != PM_SLEEP &&
                           active_src == 2'(i);
        end
      end
    end
  endgenerate

  // internal block: fast oscillator, postscaler and slow rc together
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      internal_block_en <= 3'h0;
    end else begin
      internal_block_en <= {3{pm_state != PM_SLEEP &&
                              active_src == SRC_INTERNAL}};
    end
  end

  // reset outputs; the pin is an input only, never driven low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      device_reset      <= 1'b1;
      por_pulse         <= 1'b0;
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe  <= 1'b0;
      pin_digital_in    <= 1'b0;
    end else begin
      device_reset      <= init_req;
      por_pulse         <= por_event;
      ext_reset_pin_out <= 1'b0;
      ext_reset_pin_oe  <= 1'b0;
      // plain input value, meaningful when the reset function is off
      pin_digital_in    <= ext_reset_pin_in & ~external_reset_pin_enable;
    end
  end

  // interrupt events
  assign events[EVT_IDLE]  = pm_state == PM_RUN && sleep_exec &&
                             osc_ctrl[IDLE_SEL_BIT] && !init_req;
  assign events[EVT_SLEEP] = pm_state == PM_RUN && sleep_exec &&
                             !osc_ctrl[IDLE_SEL_BIT] && !init_req;
  assign events[EVT_WAKE]  = pm_state != PM_RUN && wake_event && !init_req;
  assign events[EVT_PIN]   = pin_hold;
  assign events[EVT_POR]   = por_event;

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
    end else if (lane0_wr && address == IRQ_STATUS_OFFSET) begin
      irq_status <= (irq_status & ~writedata[EVT_W-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask <= IRQ_MASK_RESET;
    end else if (lane0_wr && address == IRQ_MASK_OFFSET) begin
      irq_mask <= writedata[EVT_W-1:0];
    end
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_idle_entry: assert property (
    (pm_state == PM_RUN && sleep_exec && osc_ctrl[IDLE_SEL_BIT] &&
     !init_req) |=> pm_state == PM_IDLE ##1 (!cpu_clk_en && periph_clk_en))
    else $error("idle not entered with idle select set");
  chk_sleep_entry: assert property (
    (pm_state == PM_RUN && sleep_exec && !osc_ctrl[IDLE_SEL_BIT] &&
     !init_req) |=> pm_state == PM_SLEEP)
    else $error("sleep not entered with idle select clear");
  chk_sleep_clocks: assert property (
    pm_state == PM_SLEEP |=>
      (!cpu_clk_en && !periph_clk_en && clk_src_en == '0 &&
       internal_block_en == 3'h0))
    else $error("clock running in sleep");
  chk_run_only_sleep: assert property (
    (pm_state == PM_RUN && !sleep_exec) |=> pm_state == PM_RUN)
    else $error("left run without a sleep instruction");
  chk_run_clocks: assert property (
    pm_state == PM_RUN |=>
      (cpu_clk_en && periph_clk_en && clk_src_en[$past(active_src)]))
    else $error("run mode without clocks");
  chk_src_switch: assert property (
    (switch_pend && source_running[sel_src] && !init_req) |=>
      active_src == $past(sel_src))
    else $error("source switch not immediate");
  chk_wake_run: assert property (
    (pm_state != PM_RUN && wake_event && !init_req) |=>
      pm_state == PM_RUN ##1 cpu_clk_en)
    else $error("wake did not return to run");
  chk_por_clears: assert property (
    por_event |=> (!por_flag && device_reset && por_pulse))
    else $error("power-on reset left flag set");
  chk_por_no_hw_set: assert property (
    $rose(por_flag) |-> $past(lane0_wr && writedata[POR_FLAG_BIT] &&
                              address == RESET_CTRL_OFFSET))
    else $error("power-on flag set without software write");
  chk_pin_no_drive: assert property (
    !ext_reset_pin_oe)
    else $error("reset pin driven");
  chk_pin_disabled: assert property (
    (!external_reset_pin_enable && !por_event) |=> !device_reset)
    else $error("disabled reset pin caused a reset");

  cov_idle: cover property (pm_state == PM_RUN ##1 pm_state == PM_IDLE);
  cov_sleep_wake: cover property (
    pm_state == PM_SLEEP ##1 pm_state == PM_RUN);
  cov_pin_reset: cover property (pin_hold ##1 device_reset);
  cov_rearm: cover property ($rose(por_flag));

endmodule

// ### tb/cpu_core_model.sv
// behavioural cpu core: executes one sleep instruction, wakes after a delay
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [7:0] wake_delay,
  output logic            sleep_exec,
  output logic            wake_event,
  output logic            busy
);
  logic [7:0] cnt;

  // one sleep pulse per start; a late wake keeps the core parked meanwhile
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sleep_exec <= 1'b0;
      wake_event <= 1'b0;
      busy       <= 1'b0;
      cnt        <= 8'h00;
    end else begin
      sleep_exec <= start && !busy;
      wake_event <= busy && cnt == 8'h01;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt  <= wake_delay;
      end else if (busy) begin
        cnt  <= cnt - 8'h01;
        busy <= cnt != 8'h01;
      end
    end
  end
endmodule

// ### tb/test_power_mode_and_reset_control.sv
// self-checking bench for the power mode and reset controller
`timescale 1ns/1ps
module test_power_mode_and_reset_control;
  import power_mode_pkg::*;
  logic              clk_sys, rst_b, read, write, waitrequest, irq;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata;
  logic [3:0]        byteenable;
  logic              sleep_exec, wake_event, supply_good, start, busy;
  logic [2:0]        source_running, clk_src_en, internal_block_en;
  logic              pin_in, pin_out, pin_oe, pin_en, pin_dig;
  logic              cpu_clk_en, periph_clk_en, device_reset, por_pulse;
  logic [7:0]        wake_delay;
  logic [31:0]       exp_q[$];
  int                fail_count, check_count, n;
  logic [1:0]        sel;

  power_mode_and_reset_control #(.FILTER_CYCLES(3))
    u_power_mode_and_reset_control (
    .clk_sys(clk_sys), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .sleep_exec(sleep_exec), .wake_event(wake_event),
    .source_running(source_running), .supply_good(supply_good),
    .ext_reset_pin_in(pin_in), .ext_reset_pin_out(pin_out),
    .ext_reset_pin_oe(pin_oe), .external_reset_pin_enable(pin_en),
    .pin_digital_in(pin_dig), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .clk_src_en(clk_src_en),
    .internal_block_en(internal_block_en), .device_reset(device_reset),
    .por_pulse(por_pulse), .irq(irq));

  cpu_core_model u_cpu_core_model (
    .clk_sys(clk_sys), .rst_b(rst_b), .start(start),
    .wake_delay(wake_delay), .sleep_exec(sleep_exec),
    .wake_event(wake_event), .busy(busy));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  // held until waitrequest is sampled low, then released for one edge
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] be);
    int k;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= !wr;
    write      <= wr;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    read  <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      fail_count++;
      print_verdict();
    end
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask

  // the expected value is queued; the watcher compares it when data lands
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0, 4'hf);
  endtask

  // wait for a level on a design or core model output, bounded
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (s !== v) begin
      fail_count++;
      print_verdict();
    end
  endtask

  function automatic logic [2:0] onehot(input logic [1:0] s);
    return s[1] ? 3'b100 : (s[0] ? 3'b010 : 3'b001);
  endfunction

  // read data and pin direction are watched on every edge
  always @(posedge clk_sys) begin
    if (rst_b && read && waitrequest === 1'b0 && exp_q.size() > 0)
      check(readdata, exp_q.pop_front());
    if (rst_b) check({pin_out, pin_oe}, 32'h0);
  end

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    rst_b = 1'b0; read = 1'b0; write = 1'b0; address = '0;
    writedata = '0; byteenable = '0; start = 1'b0; wake_delay = 8'h08;
    source_running = 3'b111; supply_good = 1'b1; pin_in = 1'b1;
    pin_en = 1'b1; fail_count = 0; check_count = 0;
    void'($urandom(80));
    cyc(2);
    rst_b <= 1'b1;
    cyc(1);
    rd(OSC_CTRL_OFFSET, 32'h0);
    rd(RESET_CTRL_OFFSET, 32'h0);
    rd(IRQ_MASK_OFFSET, 32'h0);
    wr(5'h14, 32'hff);
    rd(5'h14, 32'h0);
    // every source select code, run mode clocks follow at once
    for (int s = 0; s < 4; s++) begin
      wr(OSC_CTRL_OFFSET, 32'(s));
      cyc(3);
      check(clk_src_en, onehot(2'(s)));
      check(internal_block_en, s > 1 ? 3'h7 : 3'h0);
      check({cpu_clk_en, periph_clk_en}, 32'h3);
      rd(OSC_CTRL_OFFSET, 32'(s));
    end
    xfer(1'b1, OSC_CTRL_OFFSET, 32'h0, 4'he);
    rd(OSC_CTRL_OFFSET, 32'h3);
    // target source not running: switch waits for it
    source_running <= 3'b101;
    wr(OSC_CTRL_OFFSET, 32'h1);
    cyc(3);
    check(clk_src_en, 3'b100);
    rd(MODE_STATUS_OFFSET, 32'he0);
    source_running <= 3'b111;
    cyc(4);
    check(clk_src_en, 3'b010);
    // idle and sleep entry on random selects, then wake
    wr(IRQ_MASK_OFFSET, 32'h1f);
    for (int i = 0; i < 6; i++) begin
      sel = 2'($urandom());
      wr(OSC_CTRL_OFFSET, {24'h0, i[0], 5'h0, sel});
      wr(IRQ_STATUS_OFFSET, 32'h1f);
      cyc(2);
      check({cpu_clk_en, clk_src_en}, {28'h0, 1'b1, onehot(sel)});
      wake_delay <= 8'(6 + $urandom() % 8);
      start <= 1'b1;
      cyc(1);
      start <= 1'b0;
      wait_for(sleep_exec, 1'b1, 5);
      cyc(3);
      check({cpu_clk_en, periph_clk_en}, {30'h0, 1'b0, i[0]});
      check(clk_src_en, i[0] ? onehot(sel) : 3'h0);
      wait_for(busy, 1'b0, 20);
      cyc(4);
      check({cpu_clk_en, clk_src_en}, {28'h0, 1'b1, onehot(sel)});
      check(irq, 1'b1);
      rd(IRQ_STATUS_OFFSET, i[0] ? 32'h5 : 32'h6);
    end
    wr(IRQ_STATUS_OFFSET, 32'h1f);
    wr(IRQ_MASK_OFFSET, 32'h0);
    wr(RESET_CTRL_OFFSET, 32'h2);
    wr(OSC_CTRL_OFFSET, 32'h81);
    // a pulse shorter than the filter does nothing
    pin_in <= 1'b0;
    cyc(2);
    pin_in <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      cyc(1);
      check(device_reset, 1'b0);
    end
    pin_in <= 1'b0;
    wait_for(device_reset, 1'b1, 10);
    pin_in <= 1'b1;
    wait_for(device_reset, 1'b0, 10);
    cyc(2);
    check(irq, 1'b0);
    rd(OSC_CTRL_OFFSET, 32'h0);
    rd(RESET_CTRL_OFFSET, 32'h2);
    rd(IRQ_STATUS_OFFSET, 32'h8);
    wr(IRQ_MASK_OFFSET, 32'h8);
    cyc(3);
    check(irq, 1'b1);
    wr(IRQ_STATUS_OFFSET, 32'h8);
    cyc(3);
    check(irq, 1'b0);
    // pin reset disabled: plain input only
    pin_en <= 1'b0;
    pin_in <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      cyc(1);
      check(device_reset, 1'b0);
    end
    check(pin_dig, 1'b0);
    pin_in <= 1'b1;
    cyc(3);
    check(pin_dig, 1'b1);
    // power-on event clears the flag and the control register
    wr(OSC_CTRL_OFFSET, 32'h2);
    supply_good <= 1'b0;
    cyc(2);
    supply_good <= 1'b1;
    wait_for(por_pulse, 1'b1, 5);
    cyc(4);
    rd(RESET_CTRL_OFFSET, 32'h0);
    rd(OSC_CTRL_OFFSET, 32'h0);
    rd(IRQ_STATUS_OFFSET, 32'h10);
    wr(RESET_CTRL_OFFSET, 32'h2);
    rd(RESET_CTRL_OFFSET, 32'h2);
    cyc(3);
    print_verdict();
  end
endmodule
